// ---- src/mtq_engine.sv ----
// Purpose: Executes read, search and clear commands on the address table.
// Assumes: Command and update ports come from logic on the same clock.
// Notes:   One table entry is examined per clock while a search runs.
//
// Summary of operation
// - Read-next returns the entry at the read pointer, then pointer plus one.
// - Address in bytes five to zero, port in byte six, flags in seven.
// - Result register shows outcome; data loads on error-free completion, and byte six also on a host write.
// - First-valid returns lowest valid entry and points the pointer at it.
// - Next-valid searches forward from pointer for valid entry, points at it.
// - First/next-new return entry with new flag set and point at it.
// - First/next-aged return entry marked aged out and point at it.
// - First/next-locked return entry with lock flag and point at it.
// - First/next-filtered return entry with filter flag and point at it.
// - First-by-port returns lowest entry whose port equals data byte six.
// - Next-by-port searches forward from pointer for port matching byte six.
// - System reset reinitialises the engine and clears every table entry.
// - Result 01 while busy, 10 done, 1 plus four-bit error on failure.
// - Flag byte: valid, age, old, new, lock, filter in bits 0..5.
// - Read-first returns entry zero and leaves pointer at second entry.
`timescale 1ns/10ps
`include "mtq_cfg.svh"
module mtq_engine
  import mtq_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH),
  parameter int IW    = AW + 1
)
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_b,
  // Command port
  input  wire logic          cmd_valid,
  input  wire logic [7:0]    cmd_code,
  output logic               cmd_ready,
  output logic               cmd_done,
  // Host write of data byte six
  input  wire logic          data_six_wr,
  input  wire logic [7:0]    data_six_wdata,
  // Table update port from the lookup datapath
  input  wire logic          tbl_wr_en,
  input  wire logic [AW-1:0] tbl_wr_idx,
  input  wire mtq_entry_type tbl_wr_entry,
  // Results
  output mtq_entry_type      data_bytes,
  output logic [7:0]         result_code,
  output logic [IW-1:0]      read_ptr
);

  // Table size and step, in the width of the read pointer.
  localparam logic [IW-1:0] DEPTH_IW = IW'(DEPTH);
  localparam logic [IW-1:0] ONE_IW   = IW'(1);

  mtq_state_type state_ff;
  mtq_state_type nxt_state;
  mtq_mode_type  mode_ff;
  mtq_mode_type  nxt_mode;
  mtq_entry_type data_ff;
  mtq_entry_type nxt_data;
  logic [7:0]    result_ff;
  logic [7:0]    nxt_result;
  logic [IW-1:0] ptr_ff;
  logic [IW-1:0] nxt_ptr;
  logic [IW-1:0] idx_ff;
  logic [IW-1:0] nxt_idx;
  logic          single_ff;
  logic          nxt_single;
  logic          done_ff;
  logic          nxt_done;

  mtq_entry_type rd_entry;
  logic          hit;

  // Command decode.
  wire logic          accept    = cmd_valid && (state_ff == MTQ_ST_IDLE);
  wire logic          is_rfirst = (cmd_code == `MTQ_CMD_READ_FIRST);
  wire logic          is_rnext  = (cmd_code == `MTQ_CMD_READ_NEXT);
  wire logic          is_sysrst = (cmd_code == `MTQ_CMD_SYS_RESET);
  wire logic          is_vfirst = (cmd_code == `MTQ_CMD_VALID_FIRST);
  wire logic          is_vnext  = (cmd_code == `MTQ_CMD_VALID_NEXT);
  wire logic          is_nfirst = (cmd_code == `MTQ_CMD_NEW_FIRST);
  wire logic          is_nnext  = (cmd_code == `MTQ_CMD_NEW_NEXT);
  wire logic          is_afirst = (cmd_code == `MTQ_CMD_AGED_FIRST);
  wire logic          is_anext  = (cmd_code == `MTQ_CMD_AGED_NEXT);
  wire logic          is_lfirst = (cmd_code == `MTQ_CMD_LOCK_FIRST);
  wire logic          is_lnext  = (cmd_code == `MTQ_CMD_LOCK_NEXT);
  wire logic          is_ffirst = (cmd_code == `MTQ_CMD_FILT_FIRST);
  wire logic          is_fnext  = (cmd_code == `MTQ_CMD_FILT_NEXT);
  wire logic          is_pfirst = (cmd_code == `MTQ_CMD_PORT_FIRST);
  wire logic          is_pnext  = (cmd_code == `MTQ_CMD_PORT_NEXT);

  wire logic is_first_search = is_vfirst || is_nfirst || is_afirst ||
                               is_lfirst || is_ffirst || is_pfirst;
  wire logic is_next_search  = is_vnext || is_nnext || is_anext ||
                               is_lnext || is_fnext || is_pnext;
  wire logic is_search       = is_first_search || is_next_search;
  wire logic is_read         = is_rfirst || is_rnext;
  wire logic is_known        = is_read || is_search || is_sysrst;

  wire logic sel_valid  = is_vfirst || is_vnext;
  wire logic sel_new    = is_nfirst || is_nnext;
  wire logic sel_aged   = is_afirst || is_anext;
  wire logic sel_lock   = is_lfirst || is_lnext;
  wire logic sel_filter = is_ffirst || is_fnext;
  wire logic sel_port   = is_pfirst || is_pnext;

  // Filter selected by the command; plain reads accept any entry.
  wire mtq_mode_type cmd_mode =
    sel_valid  ? MTQ_MODE_VALID  :
    sel_new    ? MTQ_MODE_NEW    :
    sel_aged   ? MTQ_MODE_AGED   :
    sel_lock   ? MTQ_MODE_LOCK   :
    sel_filter ? MTQ_MODE_FILTER :
    sel_port   ? MTQ_MODE_PORT   : MTQ_MODE_ANY;

  // Read-next starts at the pointer itself.
  // Next searches start one entry after the read pointer.
  wire logic [IW-1:0] cmd_start =
    (is_rfirst || is_first_search) ? '0     :
    is_rnext                       ? ptr_ff : ptr_ff + ONE_IW;

  // Scan position and table read index.
  // The index carries one spare bit so that a walk past the last entry ends as a miss.
  wire logic          idx_in_range = (idx_ff < DEPTH_IW);
  wire logic [AW-1:0] rd_idx       = idx_in_range ? idx_ff[AW-1:0] : '0;
  wire logic          scan_hit     = idx_in_range && hit;
  wire logic          scan_miss    = !idx_in_range || (single_ff && !hit);

  // The clear acts on the cycle the command is taken.
  wire logic clear_all = accept && is_sysrst;

  // Port searches compare against data byte six, as the host wrote it or a returned entry loaded it.
  wire logic [7:0] want_port = data_ff.port_identifier;

  mtq_table #(
    .DEPTH    (DEPTH),
    .AW       (AW)
  ) u_table (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .wr_en    (tbl_wr_en),
    .wr_idx   (tbl_wr_idx),
    .wr_entry (tbl_wr_entry),
    .clear_all(clear_all),
    .rd_idx   (rd_idx),
    .rd_entry (rd_entry)
  );

  // Each search tests entries against the selected flag, or against byte six for port searches.
  mtq_match u_match (
    .entry    (rd_entry),
    .mode     (mode_ff),
    .want_port(want_port),
    .hit      (hit)
  );

  always_comb
  begin
    nxt_state  = state_ff;
    nxt_mode   = mode_ff;
    nxt_data   = data_ff;
    nxt_result = result_ff;
    nxt_ptr    = ptr_ff;
    nxt_idx    = idx_ff;
    nxt_single = single_ff;
    nxt_done   = 1'b0;
    // A read that completes in the same cycle overwrites this byte-six write.
    if (data_six_wr)
      nxt_data.port_identifier = data_six_wdata;
    case (state_ff)
      MTQ_ST_IDLE:
      begin
        if (accept)
        begin
          if (is_sysrst)
          begin
            // Reinitialise pointer and data with the table; result reports success.
            nxt_data   = '0;
            nxt_ptr    = '0;
            nxt_result = `MTQ_RES_OK;
            nxt_done   = 1'b1;
          end
          else if (!is_known)
          begin
            // Unsupported codes end at once with an error and change nothing.
            nxt_result = `MTQ_RES_ERR_BADCMD;
            nxt_done   = 1'b1;
          end
          else
          begin
            // Busy code while the command runs.
            nxt_result = `MTQ_RES_BUSY;
            nxt_mode   = cmd_mode;
            nxt_idx    = cmd_start;
            nxt_single = is_read;
            nxt_state  = MTQ_ST_SCAN;
          end
        end
      end
      MTQ_ST_SCAN:
      begin
        if (scan_hit)
        begin
          // Entry layout already matches the data byte order.
          // Flag byte returned with reserved bits forced low.
          // Data loads only when the command succeeds.
          nxt_data       = rd_entry;
          nxt_data.flags = rd_entry.flags & `MTQ_FLAG_USED_MASK;
          // Plain reads step the pointer past the returned entry.
          // Searches leave the pointer on the returned entry.
          nxt_ptr    = single_ff ? idx_ff + ONE_IW : idx_ff;
          nxt_result = `MTQ_RES_OK;
          nxt_done   = 1'b1;
          nxt_state  = MTQ_ST_IDLE;
        end
        else if (scan_miss)
        begin
          // Not found: data and pointer keep their values.
          nxt_result = `MTQ_RES_ERR_NOTFOUND;
          nxt_done   = 1'b1;
          nxt_state  = MTQ_ST_IDLE;
        end
        else
        begin
          // Walk forward one entry per cycle.
          nxt_idx = idx_ff + ONE_IW;
        end
      end
      default:
      begin
        nxt_state = MTQ_ST_IDLE;
      end
    endcase
  end

  // Scan control registers.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state_ff  <= MTQ_ST_IDLE;
      mode_ff   <= MTQ_MODE_ANY;
      idx_ff    <= '0;
      single_ff <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      mode_ff   <= nxt_mode;
      idx_ff    <= nxt_idx;
      single_ff <= nxt_single;
    end
  end

  // Data bytes seen by the host.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      data_ff <= '0;
    else
      data_ff <= nxt_data;
  end

  // Result code and completion pulse.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      result_ff <= `MTQ_RES_RESET;
      done_ff   <= 1'b0;
    end
    else
    begin
      result_ff <= nxt_result;
      done_ff   <= nxt_done;
    end
  end

  // Read pointer.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      ptr_ff <= '0;
    else
      ptr_ff <= nxt_ptr;
  end

  // The host may only issue a command while the engine is idle.
  assign cmd_ready   = (state_ff == MTQ_ST_IDLE);
  assign cmd_done    = done_ff;
  assign data_bytes  = data_ff;
  assign result_code = result_ff;
  assign read_ptr    = ptr_ff;

endmodule // mtq_engine

// ---- src/mtq_cfg.svh ----
// Purpose: Constants for the address table query command engine.
// Assumes: Included by bare name from the package and the engine and match modules.
// Notes:   Command codes, result codes and flag bit positions.
`ifndef MTQ_CFG_SVH
`define MTQ_CFG_SVH

// Command codes.
`define MTQ_CMD_READ_FIRST    8'h10
`define MTQ_CMD_READ_NEXT     8'h11
`define MTQ_CMD_VALID_FIRST   8'h20
`define MTQ_CMD_VALID_NEXT    8'h21
`define MTQ_CMD_NEW_FIRST     8'h30
`define MTQ_CMD_NEW_NEXT      8'h31
`define MTQ_CMD_AGED_FIRST    8'h40
`define MTQ_CMD_AGED_NEXT     8'h41
`define MTQ_CMD_LOCK_FIRST    8'h50
`define MTQ_CMD_LOCK_NEXT     8'h51
`define MTQ_CMD_FILT_FIRST    8'h60
`define MTQ_CMD_FILT_NEXT     8'h61
`define MTQ_CMD_PORT_FIRST    8'h80
`define MTQ_CMD_PORT_NEXT     8'h81
`define MTQ_CMD_SYS_RESET     8'hff

// Result codes.
`define MTQ_RES_RESET         8'h00
`define MTQ_RES_BUSY          8'h01
`define MTQ_RES_OK            8'h02
`define MTQ_RES_ERR_NOTFOUND  8'h11
`define MTQ_RES_ERR_BADCMD    8'h12

// Flag byte bit positions.
`define MTQ_FLAG_VALID        0
`define MTQ_FLAG_AGE          1
`define MTQ_FLAG_OLD          2
`define MTQ_FLAG_NEW          3
`define MTQ_FLAG_LOCK         4
`define MTQ_FLAG_FILTER       5
`define MTQ_FLAG_USED_MASK    8'h3f

// Reset values.
`define MTQ_PORT_RESET        8'h00
`define MTQ_FLAGS_RESET       8'h00
`define MTQ_MAC_RESET         48'h0000_0000_0000

`endif

// ---- src/mtq_pkg.sv ----
// Purpose: Types shared by the address table query command engine.
// Assumes: The constants header is available on the include path.
// Notes:   An entry doubles as the layout of the eight data bytes.
package mtq_pkg;
  `include "mtq_cfg.svh"

  // Byte 7 flags, byte 6 port, bytes 5..0 address, most significant first.
  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  port_identifier;
    logic [47:0] mac;
  } mtq_entry_type;

  typedef enum logic [6:0] {
    MTQ_MODE_ANY    = 7'b000_0001,
    MTQ_MODE_VALID  = 7'b000_0010,
    MTQ_MODE_NEW    = 7'b000_0100,
    MTQ_MODE_AGED   = 7'b000_1000,
    MTQ_MODE_LOCK   = 7'b001_0000,
    MTQ_MODE_FILTER = 7'b010_0000,
    MTQ_MODE_PORT   = 7'b100_0000
  } mtq_mode_type;

  typedef enum logic [1:0] {
    MTQ_ST_IDLE = 2'b01,
    MTQ_ST_SCAN = 2'b10
  } mtq_state_type;
endpackage

// ---- src/mtq_match.sv ----
// Purpose: Decides whether one table entry satisfies a search filter.
// Assumes: Pure combinational; the caller registers the outcome.
// Notes:   The port filter compares against the wanted port number.
`timescale 1ns/10ps
`include "mtq_cfg.svh"
module mtq_match
  import mtq_pkg::*;
(
  // Entry under test
  input  wire mtq_entry_type entry,
  // Filter
  input  wire mtq_mode_type  mode,
  input  wire logic [7:0]    want_port,
  // Outcome
  output logic               hit
);

  wire logic f_valid  = entry.flags[`MTQ_FLAG_VALID];
  wire logic f_new    = entry.flags[`MTQ_FLAG_NEW];
  wire logic f_old    = entry.flags[`MTQ_FLAG_OLD];
  wire logic f_lock   = entry.flags[`MTQ_FLAG_LOCK];
  wire logic f_filter = entry.flags[`MTQ_FLAG_FILTER];
  wire logic f_port   = (entry.port_identifier == want_port);

  assign hit = (mode == MTQ_MODE_ANY)    ? 1'b1     :
               (mode == MTQ_MODE_VALID)  ? f_valid  :
               (mode == MTQ_MODE_NEW)    ? f_new    :
               (mode == MTQ_MODE_AGED)   ? f_old    :
               (mode == MTQ_MODE_LOCK)   ? f_lock   :
               (mode == MTQ_MODE_FILTER) ? f_filter :
               (mode == MTQ_MODE_PORT)   ? f_port   : 1'b0;

endmodule // mtq_match

// ---- src/mtq_table.sv ----
// Purpose: Flip-flop storage of the address table.
// Assumes: One write port from the lookup datapath, one read index.
// Notes:   A clear of the whole table wins over a write in the same cycle.
`timescale 1ns/10ps
module mtq_table
  import mtq_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
)
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_b,
  // Update port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire mtq_entry_type wr_entry,
  input  wire logic          clear_all,
  // Read port
  input  wire logic [AW-1:0] rd_idx,
  output mtq_entry_type      rd_entry
);

  mtq_entry_type entry_ff [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_entry
      wire logic wr_hit = wr_en && (wr_idx == AW'(gi));
      always_ff @(posedge mclk)
      begin
        if (!rst_b || clear_all)
          entry_ff[gi] <= '0;
        else if (wr_hit)
          entry_ff[gi] <= wr_entry;
      end
    end
  endgenerate

  assign rd_entry = entry_ff[rd_idx];

endmodule // mtq_table

// ---- bench/mtq_engine_asserts.sv ----
// Purpose: Port-level timing and content checks on the query engine.
// Assumes: Bound to every engine instance; one clock domain.
// Notes:   Latencies follow the engine's command handshake.
`timescale 1ns/10ps
module mtq_engine_chk
  import mtq_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH),
  parameter int IW    = AW + 1
)
(
  // Clock and reset
  input wire logic          mclk,
  input wire logic          rst_b,
  // Command side
  input wire logic          cmd_valid,
  input wire logic [7:0]    cmd_code,
  input wire logic          cmd_ready,
  input wire logic          cmd_done,
  input wire logic          data_six_wr,
  input wire logic [7:0]    data_six_wdata,
  // Results
  input wire mtq_entry_type data_bytes,
  input wire logic [7:0]    result_code,
  input wire logic [IW-1:0] read_ptr
);
  localparam int MAXW = DEPTH + 2;
  wire logic is_scan = cmd_code[7:1] inside {7'h08, 7'h10, 7'h18, 7'h20, 7'h28, 7'h30, 7'h40};
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence s_take(logic [7:0] c);
    cmd_valid && cmd_ready && cmd_code == c;
  endsequence
  sequence s_scan_take;
    cmd_valid && cmd_ready && is_scan;
  endsequence
  sequence s_next_take;
    cmd_valid && cmd_ready && cmd_code == 8'h11 && read_ptr < DEPTH;
  endsequence
  a_busy_while_scan: assert property (s_scan_take |=>
    result_code == 8'h01 && !cmd_ready)
    else $error("busy code missing");
  a_scan_ends_bounded: assert property (s_scan_take |-> ##[2:MAXW] cmd_done)
    else $error("search did not finish");
  a_done_final_code: assert property (cmd_done |->
    result_code inside {8'h02, 8'h11, 8'h12})
    else $error("bad final code");
  a_reserved_flags_zero: assert property (data_bytes.flags[7:6] == 2'b00)
    else $error("reserved flag bits set");
  a_clear_all_done: assert property (s_take(8'hff) |=> cmd_done && result_code == 8'h02
    && read_ptr == '0 && data_bytes == '0)
    else $error("clear command wrong");
  a_first_entry_ptr: assert property (s_take(8'h10) |-> ##2 cmd_done
    && result_code == 8'h02 && read_ptr == 1)
    else $error("read first wrong");
  a_next_entry_ptr: assert property (s_next_take |-> ##2 cmd_done
    && read_ptr == $past(read_ptr, 2) + 1'b1)
    else $error("read next pointer wrong");
  a_miss_holds_state: assert property (cmd_done && result_code == 8'h11
    |-> $stable(data_bytes) && $stable(read_ptr))
    else $error("miss changed state");
  a_data_load_ok: assert property ($changed(data_bytes) && $past(rst_b)
    && !$past(data_six_wr) |-> cmd_done && result_code == 8'h02)
    else $error("data changed without success");
  a_six_write_lands: assert property (data_six_wr && cmd_ready && !cmd_valid
    |=> data_bytes.port_identifier == $past(data_six_wdata))
    else $error("byte six write lost");
endmodule // mtq_engine_chk

bind mtq_engine mtq_engine_chk #(.DEPTH(DEPTH), .AW(AW), .IW(IW)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_ready(cmd_ready), .cmd_done(cmd_done), .data_six_wr(data_six_wr),
  .data_six_wdata(data_six_wdata), .data_bytes(data_bytes), .result_code(result_code),
  .read_ptr(read_ptr));

// ---- bench/mtq_host.sv ----
// Purpose: Management processor model issuing commands to the engine.
// Assumes: Tasks are called from one bench process at a time.
// Notes:   Released command lines show the inverse of the last code.
`timescale 1ns/10ps
module mtq_host
(
  // Clock
  input  wire logic mclk,
  // Engine status
  input  wire logic cmd_ready,
  input  wire logic cmd_done,
  // Engine requests
  output logic       cmd_valid,
  output logic [7:0] cmd_code,
  output logic       data_six_wr,
  output logic [7:0] data_six_wdata
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    data_six_wr = 1'b0;
    data_six_wdata = 8'h00;
  end
  task automatic issue(input logic [7:0] code, input int gap, output bit ok);
    bit taken;
    ok = 1'b0;
    taken = 1'b0;
    repeat (gap + 1) @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge mclk);
      if (!taken && cmd_ready === 1'b1)
      begin
        taken = 1'b1;
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
      end
      else if (taken && cmd_done === 1'b1)
        ok = 1'b1;
    end
  endtask
  task automatic set_port(input logic [7:0] p);
    @(posedge mclk);
    data_six_wr <= 1'b1;
    data_six_wdata <= p;
    @(posedge mclk);
    data_six_wr <= 1'b0;
    data_six_wdata <= ~p;
  endtask
endmodule // mtq_host

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the query command engine.
// Assumes: Small table of eight entries keeps searches short.
// Notes:   A reference model predicts each result into a queue.
`timescale 1ns/10ps
module tb_top
  import mtq_pkg::*;
;
  localparam int DEPTH = 8;
  localparam int AW    = 3;
  localparam int IW    = 4;
  typedef struct packed {
    logic [7:0]    res;
    mtq_entry_type dat;
    logic [IW-1:0] ptr;
  } mtq_note_type;
  logic          mclk = 1'b0;
  logic          rst_b = 1'b0;
  logic          tbl_wr_en = 1'b0;
  logic [AW-1:0] tbl_wr_idx = '0;
  mtq_entry_type tbl_wr_entry = '0;
  wire logic     cmd_valid, cmd_ready, cmd_done, data_six_wr;
  wire logic [7:0] cmd_code, data_six_wdata, result_code;
  mtq_entry_type data_bytes, m_dat, e;
  logic [IW-1:0] read_ptr;
  mtq_entry_type tbl [DEPTH];
  mtq_note_type  notes [$];
  mtq_note_type  exp_n;
  int            m_ptr, seed = 82803, miscompares = 0, checks = 0;
  bit            ok;
  logic [7:0]    codes [21] = '{8'h10, 8'h11, 8'h11, 8'h20, 8'h21, 8'h21, 8'h30, 8'h31,
    8'h40, 8'h41, 8'h50, 8'h51, 8'h60, 8'h61, 8'h80, 8'h81, 8'h81, 8'h09, 8'hff, 8'h20, 8'h10};
  always #5 mclk = ~mclk;
  mtq_engine #(.DEPTH(DEPTH)) uut (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .data_six_wr(data_six_wr),
    .data_six_wdata(data_six_wdata), .tbl_wr_en(tbl_wr_en), .tbl_wr_idx(tbl_wr_idx),
    .tbl_wr_entry(tbl_wr_entry), .data_bytes(data_bytes), .result_code(result_code),
    .read_ptr(read_ptr));
  mtq_host host (.mclk(mclk), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .data_six_wr(data_six_wr),
    .data_six_wdata(data_six_wdata));
  task automatic flag(input string m);
    miscompares++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic bit hit(input mtq_entry_type t, input logic [7:0] code);
    case (code[7:4])
      4'h1: return 1'b1;
      4'h2: return t.flags[0];
      4'h3: return t.flags[3];
      4'h4: return t.flags[2];
      4'h5: return t.flags[4];
      4'h6: return t.flags[5];
      default: return t.port_identifier == m_dat.port_identifier;
    endcase
  endfunction
  task automatic run(input logic [7:0] code);
    mtq_note_type n;
    int k;
    n.res = 8'h12;
    k = code[0] ? m_ptr + 1 : 0;
    if (code == 8'h11)
      k = m_ptr;
    if (code == 8'hff)
    begin
      foreach (tbl[i]) tbl[i] = '0;
      m_dat = '0;
      m_ptr = 0;
      n.res = 8'h02;
    end
    else if (code[3:1] == 3'b000 && code[7:4] inside {[4'h1:4'h6], 4'h8})
    begin
      n.res = 8'h11;
      while (k < DEPTH && !hit(tbl[k], code)) k++;
      if (k < DEPTH)
      begin
        m_dat = tbl[k];
        m_dat.flags[7:6] = 2'b00;
        m_ptr = (code[7:4] == 4'h1) ? k + 1 : k;
        n.res = 8'h02;
      end
    end
    n.dat = m_dat;
    n.ptr = IW'(m_ptr);
    notes.push_back(n);
    host.issue(code, $unsigned($random(seed)) % 3, ok);
    if (!ok)
    begin
      flag("command did not complete");
      complete_run();
    end
  endtask
  task automatic do_reset();
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (tbl[i]) tbl[i] = '0;
    m_dat = '0;
    m_ptr = 0;
    @(negedge mclk);
    checks++;
    if (result_code !== 8'h00 || read_ptr !== '0 || data_bytes !== '0) flag("reset state");
  endtask
  always @(posedge mclk)
  begin
    if (cmd_done === 1'b1)
    begin
      checks++;
      if (notes.size() == 0)
        flag("result without request");
      else
      begin
        exp_n = notes.pop_front();
        if (result_code !== exp_n.res) flag("result code");
        if (data_bytes !== exp_n.dat) flag("data bytes");
        if (read_ptr !== exp_n.ptr) flag("read pointer");
      end
    end
  end
  initial
  begin
    do_reset();
    for (int r = 0; r < 8; r++)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        @(posedge mclk);
        e = {$random(seed), $random(seed)};
        e.port_identifier = {6'h00, e.port_identifier[1:0]};
        tbl[i] = e;
        tbl_wr_en <= 1'b1;
        tbl_wr_idx <= AW'(i);
        tbl_wr_entry <= e;
      end
      @(posedge mclk);
      tbl_wr_en <= 1'b0;
      m_dat.port_identifier = 8'($unsigned($random(seed)) % 4);
      host.set_port(m_dat.port_identifier);
      foreach (codes[j]) run(codes[j]);
      repeat (20) run(codes[$unsigned($random(seed)) % 21]);
    end
    do_reset();
    run(8'h11);
    repeat (4) @(posedge mclk);
    if (notes.size() != 0)
      flag("results missing");
    complete_run();
  end
endmodule // tb_top
